// file: logic/acsa_pkg.sv
/*
 * Constants for the converter's serial configuration access block:
 * configuration word layout, reset values and conversion timing.
 * Assumes a 250 MHz core clock.
 */
package acsa_pkg;
   localparam int CFG_W = 14;
   localparam int RES_W = 14;
   localparam int TX_W = RES_W + CFG_W;
   localparam int CLK_PERIOD_PS = 4000;
   // Maximum conversion time, the instant a pending word is applied
   localparam int CONV_TIME_NS = 2200;
   localparam int CONV_CYCLES = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 12;
   localparam int UPDATE_POS = 13;
   localparam int INPUT_CONFIG_FIELD_MSB = 12;
   localparam int INPUT_CONFIG_FIELD_LSB = 10;
   localparam int CHAN_MSB = 9;
   localparam int CHAN_LSB = 7;
   localparam int BW_POS = 6;
   localparam int REF_MSB = 5;
   localparam int REF_LSB = 3;
   localparam int SEQ_MSB = 2;
   localparam int SEQ_LSB = 1;
   localparam int RB_POS = 0;
   localparam logic [CFG_W-1:0] CFG_RESET = 14'h0000;
   localparam logic [CFG_W-1:0] CFG_PRELOAD = 14'h3fff;
   localparam logic [RES_W-1:0] RES_RESET = 14'h0000;
   localparam logic [1:0] DUMMY_CONVS = 2'h2;
   localparam logic [4:0] BITS_IN = 5'h0e;

   typedef enum logic [0:0] {
      ACSA_ACQUIRE = 1'b0,
      ACSA_CONVERT = 1'b1
   } acsa_state_t;

   typedef enum logic [2:0] {
      ACSA_BIP_DIFF = 3'b000,
      ACSA_BIP_COM = 3'b001,
      ACSA_TEMP = 3'b010,
      ACSA_UNI_DIFF = 3'b011,
      ACSA_UNI_COM = 3'b100,
      ACSA_UNI_GND = 3'b101
   } acsa_input_mode_t;
endpackage

// file: logic/acsa_serial_access.sv
/*
 * Serial configuration and result access of a multichannel converter.
 * Link side runs on the host's serial clock; the conversion sequencing,
 * active configuration and result snapshot run on clk. The host keeps the
 * serial clock quiet while convert_start is high and near conversion end.
 */
// Summary of operation
// - Access in acquisition n returns result n-1; config applies from acquisition n+1.
// - Access spanning into conversion n returns result n-1; config applies at n+1.
// - Configuration captured MSB first on 14 consecutive rising serial clock edges.
// - Capture depends only on serial clock edges, not on rate or continuity.
// - New configuration applied at end of maximum conversion time, one deep.
// - Configuration undefined after power-up; two dummy conversions make it valid.
// - Data input held high over two conversions loads all ones.
// - Bit 13 set replaces the configuration; clear keeps the existing one.
// - Bits 12:10 code 00X bipolar pairs, 010 bipolar against common pin.
// - Codes 011 sensor, 10X unipolar pairs, 110 against common, 111 against ground.
// - Bits 9:7 select channel in binary, 000 first to 111 eighth.
// - Bit 6 selects filter bandwidth: 0 quarter, 1 full.
// - Bits 5:3 select reference, buffer and temperature sensor enabling.
`timescale 1ns/1ps
module acsa_serial_access
   import acsa_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic convert_start,
   input wire logic sck,
   input wire logic sdi,
   output logic sdo,
   input wire logic [RES_W-1:0] result_data,
   output logic converting,
   output logic cfg_valid,
   output acsa_input_mode_t input_mode,
   output logic [2:0] input_config_field,
   output logic [2:0] channel_select_field,
   output logic filter_bandwidth_bit,
   output logic [2:0] reference_field,
   output logic [1:0] sequencer_field,
   output logic readback_enable_bit
);
   function automatic acsa_input_mode_t decode_input_config_field(input logic [2:0] code);
      acsa_input_mode_t m;
      m = ACSA_UNI_GND;
      case (code)
         3'b000, 3'b001: m = ACSA_BIP_DIFF;
         3'b010: m = ACSA_BIP_COM;
         3'b011: m = ACSA_TEMP;
         3'b100, 3'b101: m = ACSA_UNI_DIFF;
         3'b110: m = ACSA_UNI_COM;
         default: m = ACSA_UNI_GND;
      endcase
      return m;
   endfunction

   // Core domain state
   acsa_state_t state_reg, state_next;
   logic [CNT_W-1:0] conv_cnt_reg, conv_cnt_next;
   logic [CFG_W-1:0] active_reg, active_next;
   logic [RES_W-1:0] result_reg, result_next;
   logic [1:0] dummy_reg, dummy_next;
   logic clear_link_reg, clear_link_next;
   logic cnv_s1_reg, cnv_s2_reg, cnv_s3_reg;
   logic done_s1_reg, done_s2_reg;
   logic conv_end;
   logic cnv_rise;

   // Link domain state
   logic [CFG_W-1:0] shift_in_reg, shift_in_next;
   logic [4:0] in_cnt_reg, in_cnt_next;
   logic word_done_reg, word_done_next;
   logic [4:0] out_idx_reg, out_idx_next;
   logic sdo_reg, sdo_next;
   logic link_rst;
   logic [TX_W-1:0] tx_word;
   logic tx_len_long;

   assign cnv_rise = cnv_s2_reg && !cnv_s3_reg;
   assign conv_end = (state_reg == ACSA_CONVERT) && (conv_cnt_reg == CNT_W'(CONV_CYCLES - 1));

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnv_s1_reg <= 1'b0;
         cnv_s2_reg <= 1'b0;
         cnv_s3_reg <= 1'b0;
         done_s1_reg <= 1'b0;
         done_s2_reg <= 1'b0;
      end
      else
      begin
         cnv_s1_reg <= convert_start;
         cnv_s2_reg <= cnv_s1_reg;
         cnv_s3_reg <= cnv_s2_reg;
         done_s1_reg <= word_done_reg;
         done_s2_reg <= done_s1_reg;
      end
   end

   always_comb
   begin
      state_next = state_reg;
      conv_cnt_next = conv_cnt_reg;
      active_next = active_reg;
      result_next = result_reg;
      dummy_next = dummy_reg;
      clear_link_next = 1'b0;
      case (state_reg)
         ACSA_ACQUIRE:
         begin
            if (cnv_rise)
            begin
               state_next = ACSA_CONVERT;
               conv_cnt_next = '0;
            end
         end
         ACSA_CONVERT:
         begin
            conv_cnt_next = conv_cnt_reg + CNT_W'(1);
            if (conv_end)
            begin
               state_next = ACSA_ACQUIRE;
               result_next = result_data;
               clear_link_next = 1'b1;
               if (done_s2_reg && shift_in_reg[UPDATE_POS])
                  active_next = shift_in_reg;
               if (dummy_reg != DUMMY_CONVS)
                  dummy_next = dummy_reg + 2'h1;
            end
         end
         default:
            state_next = ACSA_ACQUIRE;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= ACSA_ACQUIRE;
         conv_cnt_reg <= '0;
         active_reg <= CFG_RESET;
         result_reg <= RES_RESET;
         dummy_reg <= 2'h0;
         clear_link_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         conv_cnt_reg <= conv_cnt_next;
         active_reg <= active_next;
         result_reg <= result_next;
         dummy_reg <= dummy_next;
         clear_link_reg <= clear_link_next;
      end
   end

   // Link logic is restarted by the conversion end, since sck may be idle then
   assign link_rst = rst || clear_link_reg;
   // Readback is on when its bit is clear; all-ones means no readback
   assign tx_len_long = !active_reg[RB_POS];
   // Result and configuration stay static while the host is allowed to clock
   assign tx_word = {result_reg, active_reg};

   always_comb
   begin
      shift_in_next = shift_in_reg;
      in_cnt_next = in_cnt_reg;
      word_done_next = word_done_reg;
      if (in_cnt_reg != BITS_IN)
      begin
         shift_in_next = {shift_in_reg[CFG_W-2:0], sdi};
         in_cnt_next = in_cnt_reg + 5'h1;
         word_done_next = (in_cnt_reg == BITS_IN - 5'h1);
      end
   end

   always_ff @(posedge sck or posedge link_rst)
   begin
      if (link_rst)
      begin
         shift_in_reg <= '0;
         in_cnt_reg <= 5'h0;
         word_done_reg <= 1'b0;
      end
      else
      begin
         shift_in_reg <= shift_in_next;
         in_cnt_reg <= in_cnt_next;
         word_done_reg <= word_done_next;
      end
   end

   always_comb
   begin
      sdo_next = 1'b0;
      out_idx_next = out_idx_reg;
      if ((out_idx_reg < 5'(RES_W)) || (tx_len_long && (out_idx_reg < 5'(TX_W))))
      begin
         sdo_next = tx_word[5'(TX_W - 1) - out_idx_reg];
         out_idx_next = out_idx_reg + 5'h1;
      end
   end

   always_ff @(negedge sck or posedge link_rst)
   begin
      if (link_rst)
      begin
         out_idx_reg <= 5'h0;
         sdo_reg <= 1'b0;
      end
      else
      begin
         out_idx_reg <= out_idx_next;
         sdo_reg <= sdo_next;
      end
   end

   assign sdo = sdo_reg;
   assign converting = (state_reg == ACSA_CONVERT);
   assign cfg_valid = (dummy_reg == DUMMY_CONVS);
   assign input_config_field = active_reg[INPUT_CONFIG_FIELD_MSB:INPUT_CONFIG_FIELD_LSB];
   assign input_mode = decode_input_config_field(active_reg[INPUT_CONFIG_FIELD_MSB:INPUT_CONFIG_FIELD_LSB]);
   assign channel_select_field = active_reg[CHAN_MSB:CHAN_LSB];
   assign filter_bandwidth_bit = active_reg[BW_POS];
   assign reference_field = active_reg[REF_MSB:REF_LSB];
   assign sequencer_field = active_reg[SEQ_MSB:SEQ_LSB];
   assign readback_enable_bit = !active_reg[RB_POS];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_update_word;
      conv_end && done_s2_reg && shift_in_reg[UPDATE_POS] |=> active_reg == $past(shift_in_reg);
   endproperty
   a_update_word: assert property (p_update_word) else $error("flagged word not applied");

   property p_keep_word;
      conv_end && !(done_s2_reg && shift_in_reg[UPDATE_POS]) |=> $stable(active_reg);
   endproperty
   a_keep_word: assert property (p_keep_word) else $error("config changed without update flag");

   property p_only_at_end;
      !conv_end |=> $stable(active_reg);
   endproperty
   a_only_at_end: assert property (p_only_at_end) else $error("config changed outside conversion end");

   property p_result_pipe;
      conv_end |=> (result_reg == $past(result_data)) && !converting;
   endproperty
   a_result_pipe: assert property (p_result_pipe) else $error("result not captured at conversion end");

   property p_link_clear;
      conv_end |=> clear_link_reg ##1 !clear_link_reg;
   endproperty
   a_link_clear: assert property (p_link_clear) else $error("link not restarted once");

   property p_start_conv;
      cnv_rise && !converting |=> converting && (conv_cnt_reg == '0);
   endproperty
   a_start_conv: assert property (p_start_conv) else $error("conversion did not start");

   property p_conv_holds;
      converting && !conv_end |=> converting && (conv_cnt_reg == $past(conv_cnt_reg) + CNT_W'(1));
   endproperty
   a_conv_holds: assert property (p_conv_holds) else $error("conversion cut short");

   property p_valid_rise;
      $rose(cfg_valid) |-> $past(conv_end) && $past(dummy_reg) == 2'h1;
   endproperty
   a_valid_rise: assert property (p_valid_rise) else $error("valid before two conversions");

   property p_valid_stays;
      cfg_valid |=> cfg_valid;
   endproperty
   a_valid_stays: assert property (p_valid_stays) else $error("valid dropped");

   // Result seen by the host only moves at a conversion end
   property p_result_hold;
      !conv_end |=> $stable(result_reg);
   endproperty
   a_result_hold: assert property (p_result_hold) else $error("result moved outside conversion end");

   property p_start_only_edge;
      !converting && !cnv_rise |=> !converting;
   endproperty
   a_start_only_edge: assert property (p_start_only_edge) else $error("conversion started without start edge");

   property p_dummy_step;
      conv_end && (dummy_reg != DUMMY_CONVS) |=> dummy_reg == $past(dummy_reg) + 2'h1;
   endproperty
   a_dummy_step: assert property (p_dummy_step) else $error("dummy conversion not counted");

   c_update: cover property (conv_end && done_s2_reg && shift_in_reg[UPDATE_POS]);
   c_preload: cover property (conv_end && active_next == CFG_PRELOAD);
   c_valid: cover property ($rose(cfg_valid));
   c_keep: cover property (conv_end && done_s2_reg && !shift_in_reg[UPDATE_POS]);
   c_readback: cover property (conv_end && done_s2_reg && shift_in_reg[UPDATE_POS] && !shift_in_reg[RB_POS]);
endmodule

// file: testbench/acsa_host_model.sv
/*
 * Host side model: drives convert_start, the serial clock and data in,
 * and reads data out.
 * Assumes it is called only while the converter is in acquisition.
 */
`timescale 1ns/1ps
module acsa_host_model
   import acsa_pkg::*;
(
   output logic convert_start,
   output logic sck,
   output logic sdi,
   input wire logic sdo
);
   initial
   begin
      convert_start = 1'b0;
      sck = 1'b0;
      sdi = 1'b0;
   end

   // Serial clock runs at 12 ns only inside a burst
   task automatic bits(input logic [13:0] w, input int lo, input int hi, inout logic [13:0] rd);
      for (int k = lo; k < hi; k++)
      begin
         sdi = w[13-k];
         #3 sck = 1'b1;
         #6 sck = 1'b0;
         #3 rd[13-k] = sdo;
      end
      // Released data line does not keep its last value
      sdi = ~sdi;
   endtask

   // Whole burst in acquisition, or split around the start pulse
   task automatic frame(input logic [13:0] w, input int nb, input bit span, output logic [13:0] rd,
      output logic [13:0] rb);
      int h;
      rd = 14'h0000;
      rb = 14'h0000;
      h = span ? nb / 2 : nb;
      bits(w, 0, h, rd);
      // Edges past a complete word only clock out the readback
      if (!span && nb == 14)
      begin
         #3 bits(~w, 0, 14, rb);
      end
      #40 convert_start = 1'b1;
      #40 convert_start = 1'b0;
      #40 bits(w, h, nb, rd);
   endtask
endmodule

// file: testbench/acsa_serial_access_tb_top.sv
/*
 * Self-checking bench for the serial configuration access block.
 * Assumes the host model drives the link and the bench drives result data.
 */
`timescale 1ns/1ps
module acsa_serial_access_tb_top;
   import acsa_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [RES_W-1:0] result_data = 14'h0000;
   wire convert_start, sck, sdi, sdo, converting, cfg_valid, filter_bandwidth_bit, readback_enable_bit;
   wire [2:0] input_config_field, channel_select_field, reference_field;
   wire [1:0] sequencer_field;
   acsa_input_mode_t input_mode;
   acsa_input_mode_t modes [8] = '{ACSA_BIP_DIFF, ACSA_BIP_DIFF, ACSA_BIP_COM, ACSA_TEMP,
                                    ACSA_UNI_DIFF, ACSA_UNI_DIFF, ACSA_UNI_COM, ACSA_UNI_GND};
   int n_fail = 0;
   int n_tests = 0;
   int cycles = 0;
   int nconv = 0;
   int conv_len = 0;
   integer seed = 32'h1c1f3887;
   logic [13:0] act = CFG_RESET;
   logic [13:0] exp_res = RES_RESET;
   logic [13:0] pend, rd, w;
   bit pend_ok;

   acsa_serial_access dut (.clk(clk), .rst(rst), .convert_start(convert_start), .sck(sck), .sdi(sdi),
      .sdo(sdo), .result_data(result_data), .converting(converting), .cfg_valid(cfg_valid),
      .input_mode(input_mode), .input_config_field(input_config_field),
      .channel_select_field(channel_select_field), .filter_bandwidth_bit(filter_bandwidth_bit),
      .reference_field(reference_field), .sequencer_field(sequencer_field),
      .readback_enable_bit(readback_enable_bit));
   acsa_host_model host (.convert_start(convert_start), .sck(sck), .sdi(sdi), .sdo(sdo));

   always #2 clk = ~clk;

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         n_fail++;
         results();
      end
   end

   // Length of every conversion, counted at the falling clock edge
   always @(negedge clk)
   begin
      if (converting === 1'b1)
         conv_len++;
      else if (conv_len != 0)
      begin
         check("conversion cycles", 14'(CONV_CYCLES), 14'(conv_len));
         conv_len = 0;
      end
   end

   task automatic results();
      $display("tests %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic check_cfg();
      check("fields", {1'b0, act[12:0]}, {1'b0, input_config_field, channel_select_field,
         filter_bandwidth_bit, reference_field, sequencer_field, ~readback_enable_bit});
      check("mode", {11'h000, modes[act[12:10]]}, {11'h000, input_mode});
      check("valid", {13'h0000, nconv >= 2}, {13'h0000, cfg_valid});
   endtask

   task automatic convert(input logic [13:0] wd, input int nb, input bit span);
      int t;
      logic [13:0] rb;
      @(posedge clk) result_data <= 14'($random(seed));
      host.frame(wd, nb, span, rd, rb);
      check("result", exp_res >> (14 - nb), rd >> (14 - nb));
      if (!span && nb == 14)
         check("readback", act[0] ? 14'h0000 : act, rb);
      check_cfg();
      pend_ok = (nb == 14) && wd[13];
      pend = wd;
      t = 0;
      while (converting !== 1'b1 && t < 50)
      begin
         @(negedge clk) t++;
      end
      while (converting !== 1'b0 && t < 700)
      begin
         @(negedge clk) t++;
      end
      repeat (4) @(posedge clk);
      if (pend_ok)
         act = pend;
      nconv++;
      exp_res = result_data;
      check_cfg();
   endtask

   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      check_cfg();
      repeat (2) convert(14'h3fff, 14, 1'b0);
      for (int i = 0; i < 24; i++)
      begin
         w = 14'($random(seed));
         convert(w, (i % 4 == 3) ? 9 : 14, i[0]);
      end
      for (int c = 0; c < 8; c++)
      begin
         w = 14'($random(seed));
         convert({1'b1, c[2:0], c[2:0], w[6:0]}, 14, c[0]);
      end
      results();
   end
endmodule
